/* core/pqm_params.svh */
// Purpose: Constants for the power quality event monitor.
// Assumes: 50 MHz ref_clk, signed 16-bit instantaneous samples with a strobe at the 8 kHz rate.
// Notes: Bit positions are within the event state, irq status and irq enable words, sag_peak_config and current_detector_control.
// Function
// - Peak magnitude per channel over window.
// - State always; irq status only if enabled.
// - Sag when under three samples exceed.
// - Sag period is config bits 7..0.
// - Sag status set at period end; clear after three.
// - Per-phase dip flags and enables bits 14..12.
// - Phase loss counts like sag, lower threshold.
// - Lost phase blocks its zero crossings.
// - Over-voltage while any magnitude exceeds threshold.
// - Over-voltage change flagged, can interrupt.
// - Over-current while any magnitude exceeds threshold.
// - Over-current change flagged, can interrupt.
// - Frequency outside limits sets bit 11/15.
// - Zero crossings per phase, selectable outputs.
// - Neutral current over limit sets bit 7.
// - three_wire_select selects wiring; A,B,C order.
// - Three-wire: A to C beyond 180 degrees.
// - Sequence fault sets warning bit 9.
// - Mode pins alone select four modes.
// - Normal mode: all on, detector by control.
// - Idle: stop, outputs and oscillator low.
`ifndef PQM_PARAMS_SVH
`define PQM_PARAMS_SVH
`define PQM_SAG_PERIOD_LSB   0
`define PQM_PEAK_WINDOW_LSB  8
`define PQM_NEUTRAL_OVER_BIT 7
`define PQM_OV_BIT           0
`define PQM_OI_BIT           1
`define PQM_PHASE_LOSS_BIT   2
`define PQM_SEQ_WARN_BIT     9
`define PQM_LOW_FREQ_BIT     11
`define PQM_HIGH_FREQ_BIT    15
`define PQM_DIP_LSB          12
`define PQM_DETECTOR_BIT     0
`define PQM_SAG_COUNT        2'h3
`endif

/* core/pqm_pkg.sv */
// Purpose: Types for the power quality event monitor.
// Assumes: Mode pin order is high pin then low pin.
// Notes: Codes follow the mode pin levels.
package pqm_pkg;
  typedef enum logic [1:0] {
    PQM_IDLE    = 2'h0,
    PQM_DETECT  = 2'h1,
    PQM_PARTIAL = 2'h2,
    PQM_NORMAL  = 2'h3
  } pqm_mode_t;
endpackage

/* core/pqm_level_count.sv */
// Purpose: One phase's sample counter for sag or phase-loss detection.
// Assumes: Samples arrive as magnitudes with a strobe; period_tick ends each detecting period.
// Notes: Status sets at a period with fewer than three samples above, clears on the third.
`timescale 1ns/10ps
`default_nettype none
`include "pqm_params.svh"
module pqm_level_count #(
  parameter int W = 16
) (
  input  wire  logic         ref_clk,
  input  wire  logic         rst_n,
  input  wire  logic         run,
  input  wire  logic         sample_stb,
  input  wire  logic [W-1:0] magnitude,
  input  wire  logic [W-1:0] threshold,
  input  wire  logic         period_tick,
  output logic               status,
  output logic               event_pulse
);
  typedef struct packed {
    logic [1:0] cnt;  // Samples above threshold this period, saturating.
    logic       st;   // Condition status.
    logic       ev;   // One-cycle event at period end.
  } pqm_lc_t;
  pqm_lc_t s_r, s_nxt;

  // Count samples above threshold; judge at period end.
  always_comb begin
    s_nxt    = s_r;
    s_nxt.ev = 1'b0;
    if (!run) begin
      s_nxt = '0;
    end else begin
      if (sample_stb && magnitude > threshold && s_r.cnt != `PQM_SAG_COUNT) begin
        s_nxt.cnt = s_r.cnt + 2'h1;
        if (s_r.cnt == 2'h2) begin
          s_nxt.st = 1'b0;
        end
      end
      if (period_tick) begin
        // The strobe that ends the period still counts toward it.
        if (s_nxt.cnt != `PQM_SAG_COUNT) begin
          s_nxt.st = 1'b1;
          s_nxt.ev = 1'b1;
        end
        s_nxt.cnt = '0;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status      = s_r.st;
  assign event_pulse = s_r.ev;
endmodule // pqm_level_count
`default_nettype wire

/* core/pqm_zero_cross.sv */
// Purpose: Zero crossing detector for one fundamental channel.
// Assumes: Input is the signed fundamental sample, valid on sample_stb.
// Notes: A rising crossing gives a one-cycle pulse; level shows the sign.
`timescale 1ns/10ps
`default_nettype none
module pqm_zero_cross #(
  parameter int W = 16
) (
  input  wire  logic         ref_clk,
  input  wire  logic         rst_n,
  input  wire  logic         enable,
  input  wire  logic         sample_stb,
  input  wire  logic [W-1:0] sample,
  output logic               positive,
  output logic               rise_pulse
);
  typedef struct packed {
    logic pos;
    logic rise;
  } pqm_zc_t;
  pqm_zc_t s_r, s_nxt;

  // Disabled detectors hold low so no stale crossing leaks out.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.rise = 1'b0;
    if (!enable) begin
      s_nxt = '0;
    end else if (sample_stb) begin
      s_nxt.pos  = ~sample[W-1];
      s_nxt.rise = ~sample[W-1] & ~s_r.pos;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign positive   = s_r.pos;
  assign rise_pulse = s_r.rise;
endmodule // pqm_zero_cross
`default_nettype wire

/* core/pqm_monitor.sv */
// Purpose: Power quality event monitor top: peaks, sag, phase loss, limits, sequence, modes.
// Assumes: Samples are signed, three voltage and three current channels, strobed at 8 kHz.
// Notes: Software clears irq status through one-cycle clear masks; set beats clear.
`timescale 1ns/10ps
`default_nettype none
`include "pqm_params.svh"
module pqm_monitor
  import pqm_pkg::*;
#(
  parameter int W  = 16,  // Sample and threshold width.
  parameter int FW = 16   // Frequency word width.
) (
  input  wire  logic          ref_clk,
  input  wire  logic          rst_n,
  input  wire  logic          mode_pin_high,
  input  wire  logic          mode_pin_low,
  input  wire  logic          sample_stb,
  input  wire  logic [3*W-1:0] volt_samples,
  input  wire  logic [3*W-1:0] curr_samples,
  input  wire  logic [3*W-1:0] volt_fund,
  input  wire  logic [3*W-1:0] curr_fund,
  input  wire  logic [15:0]   sag_peak_config,
  input  wire  logic [W-1:0]  overvoltage_threshold,
  input  wire  logic [W-1:0]  overcurrent_threshold,
  input  wire  logic [W-1:0]  voltage_dip_threshold,
  input  wire  logic [W-1:0]  line_missing_threshold,
  input  wire  logic [FW-1:0] measured_frequency,
  input  wire  logic [FW-1:0] low_frequency_limit,
  input  wire  logic [FW-1:0] high_frequency_limit,
  input  wire  logic [W-1:0]  neutral_rms,
  input  wire  logic [W-1:0]  neutral_current_limit,
  input  wire  logic          three_wire_select,
  input  wire  logic [5:0]    crossing_output_select,
  input  wire  logic [15:0]   current_detector_control,
  input  wire  logic [15:0]   event_irq_enable_a,
  input  wire  logic [15:0]   event_irq_enable_b,
  input  wire  logic [15:0]   irq_clear_a,
  input  wire  logic [15:0]   irq_clear_b,
  input  wire  logic          energy_pulse_in,
  input  wire  logic          warning_in,
  output logic [3*W-1:0]      volt_peak,
  output logic [3*W-1:0]      curr_peak,
  output logic [15:0]         event_state_a,
  output logic [15:0]         event_state_b,
  output logic [15:0]         event_irq_status_a,
  output logic [15:0]         event_irq_status_b,
  output logic                interrupt_line_a,
  output logic                interrupt_line_b,
  output logic [2:0]          crossing_output,
  output logic                energy_pulse_output,
  output logic                warning_output,
  output logic                crystal_drive_output,
  output logic                detector_active,
  output pqm_mode_t           power_mode
);
  // Magnitude of a signed sample; the most negative code saturates.
  function automatic logic [W-1:0] mag(input logic [W-1:0] x);
    logic [W-1:0] n;
    n = ~x + {{(W-1){1'b0}}, 1'b1};
    if (!x[W-1]) begin
      return x;
    end else if (n[W-1]) begin
      return {1'b0, {(W-1){1'b1}}};
    end else begin
      return n;
    end
  endfunction

  typedef struct packed {
    pqm_mode_t     mode;
    logic [7:0]    sag_cnt;   // Samples in current detecting period.
    logic [7:0]    peak_cnt;  // Samples in current peak window.
    logic [3*W-1:0] vpk_run;  // Running maxima.
    logic [3*W-1:0] ipk_run;
    logic [3*W-1:0] vpk;      // Published peaks.
    logic [3*W-1:0] ipk;
    logic [15:0]   st_a;
    logic [15:0]   st_b;
    logic [15:0]   is_a;
    logic [15:0]   is_b;
    logic          irq_a;
    logic          irq_b;
    logic [2:0]    zx;
    logic          cf;
    logic          warn;
    logic          osc;
    logic          det;
    logic [1:0]    seq_step;  // Expected next phase in four-wire order.
    logic [1:0]    iseq_step; // Expected next current phase; currents keep their own order.
    logic [15:0]   ac_cnt;    // Samples since phase A crossing.
    logic [15:0]   period;    // Samples between A crossings.
  } pqm_state_t;
  pqm_state_t s_r, s_nxt;

  // Mode decoding uses the pins only.
  pqm_mode_t mode_now;
  assign mode_now = pqm_mode_t'({mode_pin_high, mode_pin_low});
  logic run;
  assign run = (s_r.mode == PQM_NORMAL) || (s_r.mode == PQM_PARTIAL);

  logic period_tick;
  assign period_tick = sample_stb && (s_r.sag_cnt == sag_peak_config[`PQM_PEAK_WINDOW_LSB-1:0]);

  // Per-phase sag, phase-loss and zero crossing instances.
  logic [2:0] sag_st, sag_ev, loss_st, loss_ev, vpos, vrise, ipos, irise;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      pqm_level_count #(.W(W)) u_sag (
        .ref_clk(ref_clk), .rst_n(rst_n), .run(run), .sample_stb(sample_stb),
        .magnitude(mag(volt_samples[g*W +: W])), .threshold(voltage_dip_threshold),
        .period_tick(period_tick), .status(sag_st[g]), .event_pulse(sag_ev[g]));
      pqm_level_count #(.W(W)) u_loss (
        .ref_clk(ref_clk), .rst_n(rst_n), .run(run), .sample_stb(sample_stb),
        .magnitude(mag(volt_samples[g*W +: W])), .threshold(line_missing_threshold),
        .period_tick(period_tick), .status(loss_st[g]), .event_pulse(loss_ev[g]));
      pqm_zero_cross #(.W(W)) u_zv (
        .ref_clk(ref_clk), .rst_n(rst_n), .enable(run && !loss_st[g]),
        .sample_stb(sample_stb), .sample(volt_fund[g*W +: W]),
        .positive(vpos[g]), .rise_pulse(vrise[g]));
      pqm_zero_cross #(.W(W)) u_zi (
        .ref_clk(ref_clk), .rst_n(rst_n), .enable(run && !loss_st[g]),
        .sample_stb(sample_stb), .sample(curr_fund[g*W +: W]),
        .positive(ipos[g]), .rise_pulse(irise[g]));
    end
  endgenerate

  // Next-state logic for all monitored conditions.
  always_comb begin
    logic ov, oi, vseq_bad, iseq_bad, lof, hif, nov;
    logic [15:0] set_a, set_b;
    s_nxt = s_r;
    ov = 1'b0;
    oi = 1'b0;
    vseq_bad = 1'b0;
    iseq_bad = 1'b0;
    set_a = '0;
    set_b = '0;
    lof = measured_frequency < low_frequency_limit;
    hif = measured_frequency > high_frequency_limit;
    nov = neutral_rms > neutral_current_limit;
    s_nxt.mode = mode_now;
    for (int p = 0; p < 3; p++) begin
      if (mag(volt_samples[p*W +: W]) > overvoltage_threshold) begin
        ov = 1'b1;
      end
      if (mag(curr_samples[p*W +: W]) > overcurrent_threshold) begin
        oi = 1'b1;
      end
    end
    // Sequence: four-wire expects A,B,C; three-wire needs A to C beyond half a cycle.
    if (sample_stb) begin
      s_nxt.ac_cnt = s_r.ac_cnt + 16'h1;
    end
    if (three_wire_select) begin
      if (vrise[0]) begin
        s_nxt.period = s_r.ac_cnt;
        s_nxt.ac_cnt = '0;
      end
      if (vrise[2] && ({s_r.ac_cnt, 1'b0} <= {1'b0, s_r.period})) begin
        vseq_bad = 1'b1;
      end
      if (irise[2] && ({s_r.ac_cnt, 1'b0} <= {1'b0, s_r.period})) begin
        iseq_bad = 1'b1;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (vrise[p]) begin
          if (p[1:0] != s_r.seq_step) begin
            vseq_bad = 1'b1;
          end
          s_nxt.seq_step = (p == 2) ? 2'h0 : 2'(p + 1);
        end
        if (irise[p]) begin
          if (p[1:0] != s_r.iseq_step) begin
            iseq_bad = 1'b1;
          end
          s_nxt.iseq_step = (p == 2) ? 2'h0 : 2'(p + 1);
        end
      end
    end
    // Peak windows.
    if (run && sample_stb) begin
      s_nxt.sag_cnt  = period_tick ? 8'h0 : s_r.sag_cnt + 8'h1;
      s_nxt.peak_cnt = s_r.peak_cnt + 8'h1;
      for (int p = 0; p < 3; p++) begin
        if (mag(volt_samples[p*W +: W]) > s_r.vpk_run[p*W +: W]) begin
          s_nxt.vpk_run[p*W +: W] = mag(volt_samples[p*W +: W]);
        end
        if (mag(curr_samples[p*W +: W]) > s_r.ipk_run[p*W +: W]) begin
          s_nxt.ipk_run[p*W +: W] = mag(curr_samples[p*W +: W]);
        end
      end
      if (s_r.peak_cnt == sag_peak_config[15:`PQM_PEAK_WINDOW_LSB]) begin
        s_nxt.vpk      = s_nxt.vpk_run;
        s_nxt.ipk      = s_nxt.ipk_run;
        s_nxt.vpk_run  = '0;
        s_nxt.ipk_run  = '0;
        s_nxt.peak_cnt = '0;
      end
    end
    // State words track conditions, except the sticky sequence warnings.
    s_nxt.st_a[`PQM_OV_BIT]           = ov;
    s_nxt.st_a[`PQM_OI_BIT]           = oi;
    s_nxt.st_a[`PQM_PHASE_LOSS_BIT]   = |loss_st;
    s_nxt.st_a[`PQM_NEUTRAL_OVER_BIT] = nov;
    // Sequence warnings are sticky; a new fault beats a clear in the same cycle.
    s_nxt.st_a[`PQM_SEQ_WARN_BIT]     = vseq_bad |
      (s_r.st_a[`PQM_SEQ_WARN_BIT] & ~irq_clear_a[`PQM_SEQ_WARN_BIT]);
    s_nxt.st_b[`PQM_SEQ_WARN_BIT]     = iseq_bad |
      (s_r.st_b[`PQM_SEQ_WARN_BIT] & ~irq_clear_b[`PQM_SEQ_WARN_BIT]);
    s_nxt.st_b[`PQM_LOW_FREQ_BIT]     = lof;
    s_nxt.st_b[`PQM_HIGH_FREQ_BIT]    = hif;
    s_nxt.st_b[`PQM_DIP_LSB +: 3]     = sag_st;
    // Events: changes and present conditions.
    set_a[`PQM_OV_BIT]           = ov != s_r.st_a[`PQM_OV_BIT];
    set_a[`PQM_OI_BIT]           = oi != s_r.st_a[`PQM_OI_BIT];
    set_a[`PQM_PHASE_LOSS_BIT]   = |loss_ev;
    set_a[`PQM_NEUTRAL_OVER_BIT] = nov;
    set_a[`PQM_SEQ_WARN_BIT]     = vseq_bad;
    set_b[`PQM_SEQ_WARN_BIT]     = iseq_bad;
    set_b[`PQM_LOW_FREQ_BIT]     = lof;
    set_b[`PQM_HIGH_FREQ_BIT]    = hif;
    set_b[`PQM_DIP_LSB +: 3]     = sag_ev;
    // Sticky status: set wins over clear; only enabled bits latch.
    if (s_r.mode == PQM_NORMAL) begin
      s_nxt.is_a = (s_r.is_a & ~irq_clear_a) | (set_a & event_irq_enable_a);
      s_nxt.is_b = (s_r.is_b & ~irq_clear_b) | (set_b & event_irq_enable_b);
    end else begin
      s_nxt.is_a = s_r.is_a & ~irq_clear_a;
      s_nxt.is_b = s_r.is_b & ~irq_clear_b;
    end
    s_nxt.irq_a = |(s_nxt.is_a & event_irq_enable_a);
    s_nxt.irq_b = |(s_nxt.is_b & event_irq_enable_b);
    // Pin outputs.
    for (int p = 0; p < 3; p++) begin
      s_nxt.zx[p] = crossing_output_select[p] ? ipos[p] : vpos[p];
    end
    s_nxt.cf   = energy_pulse_in;
    s_nxt.warn = warning_in;
    s_nxt.osc  = ~s_r.osc;
    s_nxt.det  = current_detector_control[`PQM_DETECTOR_BIT];
    if (!run) begin
      // Idle and detect mode stop the sag and peak counters and hold crossing, pulse, warning and irq pins low.
      s_nxt.zx    = '0;
      s_nxt.cf    = 1'b0;
      s_nxt.warn  = 1'b0;
      s_nxt.irq_a = 1'b0;
      s_nxt.irq_b = 1'b0;
      s_nxt.osc   = mode_now != PQM_IDLE && s_r.mode != PQM_IDLE && ~s_r.osc;
      s_nxt.det   = s_r.mode == PQM_DETECT;
      s_nxt.sag_cnt  = '0;
      s_nxt.peak_cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign volt_peak            = s_r.vpk;
  assign curr_peak            = s_r.ipk;
  assign event_state_a        = s_r.st_a;
  assign event_state_b        = s_r.st_b;
  assign event_irq_status_a   = s_r.is_a;
  assign event_irq_status_b   = s_r.is_b;
  assign interrupt_line_a     = s_r.irq_a;
  assign interrupt_line_b     = s_r.irq_b;
  assign crossing_output      = s_r.zx;
  assign energy_pulse_output  = s_r.cf;
  assign warning_output       = s_r.warn;
  assign crystal_drive_output = s_r.osc;
  assign detector_active      = s_r.det;
  assign power_mode           = s_r.mode;
endmodule // pqm_monitor
`default_nettype wire

/* sim/pqm_monitor_sva.sv */
// Purpose: Port-level assertions for the power quality event monitor.
// Assumes: Bound into every pqm_monitor instance, one clock domain.
// Notes: Most checks wait for two edges of normal mode so that mode entry is never judged.
`timescale 1ns/10ps
`default_nettype none
module pqm_monitor_sva
  import pqm_pkg::*;
#(
  parameter int W  = 16,
  parameter int FW = 16
) (
  input wire logic           ref_clk,
  input wire logic           rst_n,
  input wire logic           mode_pin_high,
  input wire logic           mode_pin_low,
  input wire logic           sample_stb,
  input wire logic [3*W-1:0] volt_samples,
  input wire logic [W-1:0]   overvoltage_threshold,
  input wire logic [FW-1:0]  measured_frequency,
  input wire logic [FW-1:0]  low_frequency_limit,
  input wire logic [FW-1:0]  high_frequency_limit,
  input wire logic [15:0]    current_detector_control,
  input wire logic [15:0]    event_irq_enable_a,
  input wire logic [15:0]    irq_clear_a,
  input wire logic [15:0]    event_state_a,
  input wire logic [15:0]    event_state_b,
  input wire logic [15:0]    event_irq_status_a,
  input wire logic           interrupt_line_a,
  input wire logic [2:0]     crossing_output,
  input wire logic           energy_pulse_output,
  input wire logic           warning_output,
  input wire logic           crystal_drive_output,
  input wire logic           detector_active,
  input wire pqm_mode_t      power_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic was_normal_r; // Normal mode seen at the previous edge.
  logic steady;       // Normal mode at this edge and the one before.
  logic ov_any;       // Some phase voltage magnitude is above the limit.
  // Cleared by reset, so the first edges after any release are never judged.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      was_normal_r <= 1'b0;
    end else begin
      was_normal_r <= power_mode == PQM_NORMAL;
    end
  end
  // Magnitudes make both half-cycles count alike.
  always_comb begin
    logic [W-1:0] s;
    s = '0;
    steady = was_normal_r && power_mode == PQM_NORMAL;
    ov_any = 1'b0;
    for (int p = 0; p < 3; p++) begin
      s = volt_samples[p*W +: W];
      ov_any = ov_any | ((s[W-1] ? -s : s) > overvoltage_threshold);
    end
  end
  mode_map_a: assert property ($past(rst_n) |-> power_mode == $past({mode_pin_high, mode_pin_low}))
    else $error("power mode differs from the pins");
  idle_quiet_a: assert property (power_mode == PQM_IDLE && $past(power_mode) == PQM_IDLE |->
    {crossing_output, energy_pulse_output, warning_output, interrupt_line_a, crystal_drive_output} == 7'h00)
    else $error("an output is not low in idle");
  ov_state_a: assert property (steady && $past(sample_stb) |-> event_state_a[0] == $past(ov_any))
    else $error("over-voltage state wrong");
  irq_gate_a: assert property ($rose(event_irq_status_a[0]) |-> $past(event_irq_enable_a[0]))
    else $error("status latched while disabled");
  irq_line_a: assert property (steady && $stable(event_irq_enable_a) |->
    interrupt_line_a == |(event_irq_status_a & event_irq_enable_a)) else $error("interrupt line wrong");
  sticky_a: assert property (steady |->
    ($past(event_irq_status_a) & ~$past(irq_clear_a) & ~event_irq_status_a) == 16'h0000)
    else $error("status bit fell without a clear");
  freq_flags_a: assert property (steady |->
    event_state_b[11] == $past(measured_frequency < low_frequency_limit) &&
    event_state_b[15] == $past(measured_frequency > high_frequency_limit)) else $error("frequency flags wrong");
  detector_on_a: assert property (steady |-> detector_active == $past(current_detector_control[0]))
    else $error("detector enable wrong");
  cover property (steady && event_state_a[0]);
  cover property (|event_state_b[14:12]);
  cover property (power_mode == PQM_PARTIAL);
endmodule // pqm_monitor_sva
bind pqm_monitor pqm_monitor_sva #(.W(W), .FW(FW)) pqm_sva_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .mode_pin_high(mode_pin_high), .mode_pin_low(mode_pin_low),
  .sample_stb(sample_stb), .volt_samples(volt_samples), .overvoltage_threshold(overvoltage_threshold),
  .measured_frequency(measured_frequency), .low_frequency_limit(low_frequency_limit),
  .high_frequency_limit(high_frequency_limit), .current_detector_control(current_detector_control),
  .event_irq_enable_a(event_irq_enable_a), .irq_clear_a(irq_clear_a), .event_state_a(event_state_a),
  .event_state_b(event_state_b), .event_irq_status_a(event_irq_status_a), .interrupt_line_a(interrupt_line_a),
  .crossing_output(crossing_output), .energy_pulse_output(energy_pulse_output), .warning_output(warning_output),
  .crystal_drive_output(crystal_drive_output), .detector_active(detector_active), .power_mode(power_mode)
);
`default_nettype wire

/* sim/pqm_host_model.sv */
// Purpose: Host controller model that drives the two power mode pins.
// Assumes: A request is a mode code with a one-cycle strobe.
// Notes: Requests arriving during an idle passage are lost; the bench spaces them.
`timescale 1ns/10ps
`default_nettype none
module pqm_host_model
  import pqm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      req_stb,
  input  wire pqm_mode_t req_mode,
  output wire logic      mode_pin_high,
  output wire logic      mode_pin_low
);
  pqm_mode_t pins_r = PQM_IDLE; // Pins start at defined levels, never floating.
  assign {mode_pin_high, mode_pin_low} = pins_r;
  // An active-to-active change spends four cycles in idle first.
  always @(posedge ref_clk) begin
    if (req_stb) begin
      if (pins_r != PQM_IDLE && req_mode != PQM_IDLE) begin
        pins_r <= #1 PQM_IDLE;
        repeat (4) @(posedge ref_clk);
      end
      pins_r <= #1 req_mode;
    end
  end
endmodule // pqm_host_model
`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the power quality event monitor.
// Assumes: Inputs change 1 ns after the rising edge; one sample strobe every four cycles.
// Notes: Mode changes go through the host model, which passes through idle between two active modes.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pqm_pkg::*;
  logic        ref_clk, rst_n, stb, rq, ep_in, wn_in, tw, mph, mpl, il_a, il_b, xo, ep_o, wn_o, det;
  pqm_mode_t   rq_mode, pm;
  logic [47:0] vs, cs, vf, cf, vp, cp;
  logic [15:0] cfg, ovt, oit, dpt, lst, frq, flo, fhi, nrm, nlim, dctl, ena, enb, cla, clb, sa, sb, isa, isb;
  logic [5:0]  sel;
  logic [2:0]  cx;
  logic [15:0] pk [4] = '{16'h0064, 16'hfed4, 16'h00c8, 16'h0032}; // Peak magnitude is 300.
  int          n_mismatch, total_checks;
  pqm_host_model host_u (.ref_clk(ref_clk), .req_stb(rq), .req_mode(rq_mode), .mode_pin_high(mph),
    .mode_pin_low(mpl));
  pqm_monitor dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .mode_pin_high(mph), .mode_pin_low(mpl),
    .sample_stb(stb), .volt_samples(vs), .curr_samples(cs), .volt_fund(vf), .curr_fund(cf),
    .sag_peak_config(cfg), .overvoltage_threshold(ovt), .overcurrent_threshold(oit),
    .voltage_dip_threshold(dpt), .line_missing_threshold(lst), .measured_frequency(frq),
    .low_frequency_limit(flo), .high_frequency_limit(fhi), .neutral_rms(nrm), .neutral_current_limit(nlim),
    .three_wire_select(tw), .crossing_output_select(sel), .current_detector_control(dctl),
    .event_irq_enable_a(ena), .event_irq_enable_b(enb), .irq_clear_a(cla), .irq_clear_b(clb),
    .energy_pulse_in(ep_in), .warning_in(wn_in), .volt_peak(vp), .curr_peak(cp), .event_state_a(sa),
    .event_state_b(sb), .event_irq_status_a(isa), .event_irq_status_b(isb), .interrupt_line_a(il_a),
    .interrupt_line_b(il_b), .crossing_output(cx), .energy_pulse_output(ep_o), .warning_output(wn_o),
    .crystal_drive_output(xo), .detector_active(det), .power_mode(pm));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Fundamental pattern with phase p positive and the others negative.
  function automatic logic [47:0] pos(input int p);
    pos = {3{16'hffce}};
    pos[p*16 +: 16] = 16'h0032;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      stb = 1'b1;
      tick(1);
      stb = 1'b0;
      tick(3);
    end
  endtask
  task automatic go(input pqm_mode_t m);
    rq_mode = m;
    rq = 1'b1;
    tick(1);
    rq = 1'b0;
    tick(10);
  endtask
  task automatic clr(input logic [15:0] m);
    {cla, clb} = {m, m};
    tick(1);
    {cla, clb} = '0;
    tick(1);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hang stops at 3000 cycles, about ten times the few hundred the tests need.
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {stb, rq, tw, rst_n, sel, nrm, cs, cla, clb, ep_in, wn_in} = 2'b11;
    rq_mode = PQM_IDLE;
    {vs, vf, cf} = {{3{16'h02bc}}, pos(0), pos(0)};
    {cfg, ovt, oit, dpt, lst, frq, flo, fhi} = {16'h0307, 16'h03e8, 16'h03e8, 16'h01f4, 16'h0064, 16'h0032,
      16'h002d, 16'h0037};
    {nlim, dctl, ena, enb, n_mismatch, total_checks} = {16'h00c8, 16'h0001, 16'hfffd, 16'hffff, 64'h0};
    tick(2);
    rst_n = 1'b1;
    go(PQM_NORMAL);
    chk(pm, PQM_NORMAL);
    chk({ep_o, wn_o}, 2'b11);
    for (int i = 0; i < 2; i++) begin
      dctl = 16'(i);
      tick(2);
      chk(det, 16'(i));
    end
    strobe(16);
    clr(16'hffff);
    $display("test modes done");
    {vs[31:16], cs[47:32]} = {16'hfb50, 16'h05dc};
    strobe(1);
    chk(sa[1:0], 2'b11);
    chk({isa[1:0], il_a}, 3'b011);
    {vs[31:16], cs} = {16'h02bc, 48'h0};
    strobe(1);
    chk({sa[1:0], isa[0]}, 3'b001);
    clr(16'hffff);
    chk(il_a, 1'b0);
    $display("test limits done");
    frq = 16'h0028;
    tick(2);
    chk({sb[15], sb[11], isb[11], il_b}, 4'b0111);
    frq = 16'h003c;
    tick(2);
    chk({sb[15], sb[11], isb[15]}, 3'b101);
    {frq, nrm} = {16'h0032, 16'h012c};
    tick(2);
    chk({sa[7], isa[7], il_a}, 3'b111);
    nrm = '0;
    {vf, cf} = {pos(0), ~pos(0)};
    strobe(1);
    chk(cx, 3'b001);
    sel = 6'h07;
    tick(2);
    chk(cx, 3'b110);
    sel = '0;
    clr(16'hffff);
    $display("test frequency neutral crossing done");
    for (int i = 0; i < 6; i++) begin
      {vf, cf} = {2{pos((8 - i) % 3)}};
      strobe(1);
    end
    chk({sa[9], sb[9]}, 2'b11);
    clr(16'h0200);
    for (int i = 0; i < 6; i++) begin
      {vf, cf} = {2{pos(i % 3)}};
      strobe(1);
    end
    chk({sa[9], sb[9]}, 2'b00);
    for (int i = 0; i < 8; i++) begin
      cs[15:0] = pk[i % 4];
      strobe(1);
    end
    chk(cp[15:0], 16'h012c);
    chk(vp[31:16], 16'h02bc);
    $display("test sequence peak done");
    {vs[15:0], vf, cf} = {16'h0000, pos(0), pos(0)};
    strobe(18);
    chk({sb[14:12], isb[12], sa[2]}, 5'b00111);
    chk(cx[0], 1'b0);
    vs[15:0] = 16'h02bc;
    strobe(5);
    chk(sb[12], 1'b0);
    $display("test sag done");
    go(PQM_PARTIAL);
    chk(pm, PQM_PARTIAL);
    go(PQM_IDLE);
    chk({cx, ep_o, wn_o, il_a, il_b, xo}, 8'h00);
    go(PQM_DETECT);
    chk(pm, PQM_DETECT);
    $display("test power modes done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
